// *** eep_pkg.sv ***
// shared constants and types for the two-wire eeprom link
package eep_pkg;
  localparam logic [3:0] DEV_TYPE_CODE   = 4'ha;
  localparam int         SEL_PINS        = 3;
  localparam int         ADDR_RW_BIT     = 0;
  localparam int         ADDR_SEL_LSB    = 1;
  localparam int         ADDR_TYPE_LSB   = 4;
  localparam int         WORD_W          = 8;
  localparam int         PAGE_W          = 4;
  localparam int         PAGE_BYTES      = 16;
  localparam int         KBIT_BYTES      = 128;
  localparam int         MEM_KBIT_DEF    = 16;
  localparam logic [3:0] LAST_BIT        = 4'h7;
  localparam logic [3:0] ACK_SLOT        = 4'h8;
  localparam logic       ACK_BIT         = 1'b0;
  localparam logic       RD_DIR          = 1'b1;
  localparam int         SYS_CLK_NS      = 50;
  localparam int         T_WR_MAX_NS     = 10_000_000;
  // longest time: rounds down
  localparam int         WR_CYCLES_DEF   = T_WR_MAX_NS / SYS_CLK_NS;
  localparam int         F_SCL_MAX_KHZ   = 100;
  localparam int         T_SCL_MIN_NS    = 1_000_000 / F_SCL_MAX_KHZ;
  // least time per quarter bit: rounds up
  localparam int         SCL_QUARTER_CYC =
    (T_SCL_MIN_NS + 4 * SYS_CLK_NS - 1) / (4 * SYS_CLK_NS);
  typedef enum logic [1:0] {
    OP_WRITE, OP_RAND_READ, OP_CUR_READ, OP_POLL
  } eep_op_e;
endpackage

// *** eep_link_if.sv ***
// two-wire link between bus master and eeprom end
`timescale 1ns/1ps
interface eep_link_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic sda;
  // open drain with pull-up: any enabled low driver wins
  assign sda = ~((~m_sda_oe_n & ~m_sda_o) | (~s_sda_oe_n & ~s_sda_o));
  modport host   (output scl, m_sda_o, m_sda_oe_n, input sda);
  modport memory (input scl, sda, output s_sda_o, s_sda_oe_n);
endinterface

// *** eep_sync.sv ***
// two flip-flop level synchroniser
`timescale 1ns/1ps
module eep_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  always_comb begin
    next_meta = d_i;
    next_q    = meta;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end
endmodule // eep_sync

// *** eep_mem_end.sv ***
// eeprom end: two-wire slave, page buffer, self-timed write
//
// Summary of operation
// - device type code 1010 must match
// - select pins compared; unused pins ignored
// - spare address bits pick page block
// - random read: dummy write, restart, read
// - master ack requests next byte
// - address counter wraps over whole array on reads
// - counter keeps last address plus one
// - write cycle starts at stop
// - inputs ignored, no ack while busy
// - busy lasts at most 10 ms
// - page write up to sixteen bytes
// - all bytes loaded into the page programmed in one cycle; other bytes kept
// - master keeps clock at most 100 kHz
// - write poll: no ack until done
`timescale 1ns/1ps
module eep_mem_end
  import eep_pkg::*;
#(
  parameter int MEM_KBIT  = eep_pkg::MEM_KBIT_DEF,
  parameter int WR_CYCLES = eep_pkg::WR_CYCLES_DEF
) (
  input  wire logic  clk_sys_i,
  input  wire logic  rstn_i,
  eep_link_if.memory link,
  input  wire logic  device_select_pin_0_i,
  input  wire logic  device_select_pin_1_i,
  input  wire logic  device_select_pin_2_i,
  output logic       busy_o
);
  localparam int MEM_BYTES = MEM_KBIT * KBIT_BYTES;
  localparam int ADDR_W    = $clog2(MEM_BYTES);
  localparam int BLK_W     = ADDR_W - WORD_W;
  localparam int CNT_W     = $clog2(WR_CYCLES + 1);

  if (!(MEM_KBIT == 2 || MEM_KBIT == 4 || MEM_KBIT == 8 ||
        MEM_KBIT == 16) || WR_CYCLES < 1) begin : g_bad
    $error("eep_mem_end: unsupported size or write time");
  end

  typedef enum logic [2:0] {
    ST_DEV, ST_ADDR, ST_WDATA, ST_RDATA, ST_IGNORE
  } eep_lstate_e;

  logic [WORD_W-1:0] mem  [MEM_BYTES];
  logic [WORD_W-1:0] pbuf [PAGE_BYTES];

  ////////////////////////////////////////////////////////////////////////////
  // system domain: start/stop detect, link hold, write timer

  logic [1:0]       pin_s;
  logic             scl_s;
  logic             sda_s;
  logic             scl_d;
  logic             sda_d;
  logic             hold;
  logic             armed;
  logic [CNT_W-1:0] wr_cnt;
  logic             wr_pend_s;
  logic             next_scl_d;
  logic             next_sda_d;
  logic             next_hold;
  logic             next_armed;
  logic             next_busy;
  logic [CNT_W-1:0] next_wr_cnt;
  logic             start_ev;
  logic             stop_ev;
  logic             release_ev;
  logic             prog;
  logic             link_rst_n;
  logic             wr_pend;
  logic [PAGE_BYTES-1:0] wmask;
  logic [ADDR_W-1:0]     ptr;

  eep_sync #(.WIDTH(2)) u_pin_sync (
    .clk_i  (clk_sys_i),
    .rstn_i (rstn_i),
    .d_i    ({link.scl, link.sda}),
    .q_o    (pin_s)
  );

  eep_sync #(.WIDTH(1)) u_pend_sync (
    .clk_i  (clk_sys_i),
    .rstn_i (rstn_i),
    .d_i    (wr_pend),
    .q_o    (wr_pend_s)
  );

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  always_comb begin
    start_ev    = scl_s && scl_d && sda_d && !sda_s;
    stop_ev     = scl_s && scl_d && !sda_d && sda_s;
    prog        = stop_ev && wr_pend_s && !busy_o;
    release_ev  = armed && !scl_s && !busy_o;
    next_scl_d  = scl_s;
    next_sda_d  = sda_s;
    next_busy   = busy_o;
    next_wr_cnt = wr_cnt;
    if (prog) begin
      next_busy   = 1'b1;
      next_wr_cnt = CNT_W'(WR_CYCLES - 1);
    end else if (busy_o) begin
      if (wr_cnt == '0) next_busy = 1'b0;
      else next_wr_cnt = wr_cnt - 1'b1;
    end
    next_armed = armed;
    if (start_ev) next_armed = 1'b1;
    // a start seen while busy is never armed: no ack to a poll
    if (busy_o || stop_ev || release_ev) next_armed = 1'b0;
    next_hold = hold;
    if (start_ev || stop_ev || prog || busy_o) next_hold = 1'b1;
    else if (release_ev) next_hold = 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
      hold   <= 1'b1;
      armed  <= 1'b0;
      busy_o <= 1'b0;
      wr_cnt <= '0;
    end else begin
      scl_d  <= next_scl_d;
      sda_d  <= next_sda_d;
      hold   <= next_hold;
      armed  <= next_armed;
      busy_o <= next_busy;
      wr_cnt <= next_wr_cnt;
    end
  end

  // page buffer, mask and pointer are still at rest when stop is seen,
  // wr_pend_s qualifies them; hold clears the mask only afterwards
  always_ff @(posedge clk_sys_i) begin
    if (prog) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (wmask[i]) begin
          mem[{ptr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= pbuf[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: byte engine on the serial clock

  // frame logic is held in reset between frames and while busy
  assign link_rst_n = rstn_i & ~hold;

  eep_lstate_e          lstate;
  eep_lstate_e          next_lstate;
  logic [3:0]           bit_cnt;
  logic [3:0]           next_bit_cnt;
  logic [WORD_W-1:0]    shreg;
  logic [WORD_W-1:0]    next_shreg;
  logic [WORD_W-1:0]    rx_byte;
  logic                 ack_due;
  logic                 next_ack_due;
  logic [SEL_PINS-1:0]  dev_sel;
  logic [SEL_PINS-1:0]  next_dev_sel;
  logic                 next_wr_pend;
  logic [PAGE_BYTES-1:0] next_wmask;
  logic [ADDR_W-1:0]    next_ptr;
  logic                 pbuf_we;
  logic [SEL_PINS-1:0]  pins_s;
  logic [SEL_PINS-1:0]  sel_ok;
  logic                 dev_hit;
  logic                 drive_low;

  eep_sync #(.WIDTH(SEL_PINS)) u_sel_sync (
    .clk_i  (link.scl),
    .rstn_i (rstn_i),
    .d_i    ({device_select_pin_2_i, device_select_pin_1_i,
              device_select_pin_0_i}),
    .q_o    (pins_s)
  );

  assign rx_byte = {shreg[WORD_W-2:0], link.sda};

  for (genvar g = 0; g < SEL_PINS; g++) begin : g_sel
    // low select bits carry the page block on larger parts
    assign sel_ok[g] = (g < BLK_W) ||
                       (rx_byte[ADDR_SEL_LSB+g] == pins_s[g]);
  end

  assign dev_hit = (rx_byte[ADDR_TYPE_LSB+:$bits(DEV_TYPE_CODE)]
                    == DEV_TYPE_CODE) && (&sel_ok);

  always_comb begin
    next_lstate  = lstate;
    next_bit_cnt = bit_cnt;
    next_shreg   = shreg;
    next_ack_due = ack_due;
    next_dev_sel = dev_sel;
    next_wr_pend = wr_pend;
    next_wmask   = wmask;
    next_ptr     = ptr;
    pbuf_we      = 1'b0;
    case (lstate)
      ST_DEV, ST_ADDR, ST_WDATA: begin
        if (bit_cnt != ACK_SLOT) begin
          next_shreg   = rx_byte;
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt == LAST_BIT) begin
            next_ack_due = (lstate != ST_DEV) || dev_hit;
          end
        end else begin
          next_bit_cnt = '0;
          next_ack_due = 1'b0;
          if (lstate == ST_DEV) begin
            if (!ack_due) begin
              next_lstate = ST_IGNORE;
            end else if (shreg[ADDR_RW_BIT] == RD_DIR) begin
              next_lstate = ST_RDATA;
              next_shreg  = mem[ptr];
              next_ptr    = ptr + 1'b1;
            end else begin
              next_lstate  = ST_ADDR;
              next_dev_sel = shreg[ADDR_SEL_LSB+:SEL_PINS];
            end
          end else if (lstate == ST_ADDR) begin
            next_lstate = ST_WDATA;
            next_ptr    = ADDR_W'({dev_sel, shreg});
          end else begin
            pbuf_we                     = 1'b1;
            next_wmask[ptr[PAGE_W-1:0]] = 1'b1;
            next_wr_pend                = 1'b1;
            // writes wrap inside the current page
            next_ptr = {ptr[ADDR_W-1:PAGE_W],
                        ptr[PAGE_W-1:0] + PAGE_W'(1)};
          end
        end
      end
      ST_RDATA: begin
        if (bit_cnt != ACK_SLOT) begin
          next_shreg   = shreg << 1;
          next_bit_cnt = bit_cnt + 4'h1;
        end else if (link.sda == ACK_BIT) begin
          next_shreg   = mem[ptr];
          next_ptr     = ptr + 1'b1;
          next_bit_cnt = '0;
        end else begin
          next_lstate = ST_IGNORE;
        end
      end
      default: begin
        next_lstate = ST_IGNORE;
      end
    endcase
    if (lstate == ST_RDATA) begin
      drive_low = (bit_cnt != ACK_SLOT) && !shreg[WORD_W-1];
    end else begin
      drive_low = ack_due && (bit_cnt == ACK_SLOT);
    end
  end

  always_ff @(posedge link.scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lstate  <= ST_DEV;
      bit_cnt <= '0;
      shreg   <= '0;
      ack_due <= 1'b0;
      dev_sel <= '0;
      wr_pend <= 1'b0;
      wmask   <= '0;
    end else begin
      lstate  <= next_lstate;
      bit_cnt <= next_bit_cnt;
      shreg   <= next_shreg;
      ack_due <= next_ack_due;
      dev_sel <= next_dev_sel;
      wr_pend <= next_wr_pend;
      wmask   <= next_wmask;
    end
  end

  // the pointer survives frames: only power-on reset clears it
  always_ff @(posedge link.scl or negedge rstn_i) begin
    if (!rstn_i) ptr <= '0;
    else ptr <= next_ptr;
  end

  always_ff @(posedge link.scl) begin
    if (pbuf_we) pbuf[ptr[PAGE_W-1:0]] <= shreg;
  end

  // data changes only while the clock is low
  always_ff @(negedge link.scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      link.s_sda_oe_n <= 1'b1;
      link.s_sda_o    <= 1'b0;
    end else begin
      link.s_sda_oe_n <= ~drive_low;
      link.s_sda_o    <= 1'b0;
    end
  end
endmodule // eep_mem_end

// *** eep_host_end.sv ***
// bus master end: command driven two-wire transfers
`timescale 1ns/1ps
module eep_host_end
  import eep_pkg::*;
#(
  parameter int QUARTER = eep_pkg::SCL_QUARTER_CYC
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rstn_i,
  eep_link_if.host                   link,
  input  wire logic                  cmd_valid_i,
  output logic                       cmd_ready_o,
  input  eep_pkg::eep_op_e           cmd_op_i,
  input  wire logic [2:0]            cmd_sel_i,
  input  wire logic [7:0]            cmd_addr_i,
  input  wire logic [3:0]            cmd_len_i,
  input  wire logic [7:0]            wr_data_i,
  output logic                       wr_take_o,
  output logic                       rd_valid_o,
  output logic [7:0]                 rd_data_o,
  output logic                       done_o,
  output logic                       nack_o
);
  localparam int QW = $clog2(QUARTER + 1);

  if (QUARTER < SCL_QUARTER_CYC) begin : g_bad
    $error("eep_host_end: serial clock above limit");
  end

  typedef enum logic [2:0] {H_IDLE, H_START, H_TX, H_RX, H_STOP} eep_hst_e;
  typedef enum logic [1:0] {W_DEV1, W_ADDR, W_DATA, W_DEV2} eep_what_e;

  eep_hst_e          hst, next_hst;
  eep_what_e         what, next_what;
  eep_op_e           op, next_op;
  logic [QW-1:0]     qcnt, next_qcnt;
  logic [1:0]        ph, next_ph;
  logic [3:0]        bitn, next_bitn;
  logic [WORD_W-1:0] shreg, next_shreg;
  logic [2:0]        sel, next_sel;
  logic [7:0]        addr, next_addr;
  logic [3:0]        remain, next_remain;
  logic              nack, next_nack;
  logic              samp, next_samp;
  logic              sda_s;
  logic              tick;
  logic              bit_end;
  logic              scl_hi;
  logic              sda_low;
  logic              next_ready, next_take, next_rd_valid, next_done;
  logic [7:0]        next_rd_data;

  eep_sync #(.WIDTH(1)) u_sda_sync (
    .clk_i  (clk_sys_i),
    .rstn_i (rstn_i),
    .d_i    (link.sda),
    .q_o    (sda_s)
  );

  always_comb begin
    next_hst = hst;  next_what = what;  next_op = op;
    next_qcnt = qcnt;  next_ph = ph;  next_bitn = bitn;
    next_shreg = shreg;  next_sel = sel;  next_addr = addr;
    next_remain = remain;  next_nack = nack;  next_samp = samp;
    next_ready = cmd_ready_o;  next_take = 1'b0;
    next_rd_valid = 1'b0;  next_rd_data = rd_data_o;
    next_done = 1'b0;
    tick    = qcnt == QW'(QUARTER - 1);
    bit_end = tick && (ph == 2'h3);
    if (hst != H_IDLE) begin
      next_qcnt = tick ? '0 : qcnt + 1'b1;
      if (tick) next_ph = ph + 2'h1;
      if (tick && ph == 2'h2) next_samp = sda_s;
    end
    case (hst)
      H_IDLE: begin
        if (cmd_valid_i && cmd_ready_o) begin
          next_hst = H_START;  next_what = W_DEV1;  next_op = cmd_op_i;
          next_sel = cmd_sel_i;  next_addr = cmd_addr_i;
          next_remain = cmd_len_i;  next_nack = 1'b0;  next_ready = 1'b0;
          next_qcnt = '0;  next_ph = '0;
        end
      end
      H_START: begin
        if (bit_end) begin
          next_hst = H_TX;  next_bitn = '0;
          next_what = (what == W_ADDR) ? W_DEV2 : W_DEV1;
          next_shreg = {DEV_TYPE_CODE, sel,
                        (what == W_ADDR) || (op == OP_CUR_READ)};
        end
      end
      H_TX: begin
        if (bit_end && bitn != ACK_SLOT) begin
          next_bitn = bitn + 4'h1;  next_shreg = shreg << 1;
        end else if (bit_end) begin
          next_bitn = '0;
          if (samp != ACK_BIT) begin
            next_nack = 1'b1;  next_hst = H_STOP;
          end else begin
            case (what)
              W_DEV1: begin
                if (op == OP_POLL) next_hst = H_STOP;
                else if (op == OP_CUR_READ) next_hst = H_RX;
                else begin
                  next_what = W_ADDR;  next_shreg = addr;
                end
              end
              W_ADDR: begin
                if (op == OP_RAND_READ) next_hst = H_START;
                else begin
                  next_what = W_DATA;  next_shreg = wr_data_i;
                  next_take = 1'b1;
                end
              end
              W_DATA: begin
                if (remain == '0) next_hst = H_STOP;
                else begin
                  next_remain = remain - 1'b1;
                  next_shreg = wr_data_i;  next_take = 1'b1;
                end
              end
              default: next_hst = H_RX;
            endcase
          end
        end
      end
      H_RX: begin
        if (bit_end && bitn != ACK_SLOT) begin
          next_bitn = bitn + 4'h1;  next_shreg = {shreg[WORD_W-2:0], samp};
          if (bitn == LAST_BIT) begin
            next_rd_valid = 1'b1;
            next_rd_data = {shreg[WORD_W-2:0], samp};
          end
        end else if (bit_end) begin
          next_bitn = '0;
          if (remain == '0) next_hst = H_STOP;
          else next_remain = remain - 1'b1;
        end
      end
      default: begin
        if (bit_end) begin
          next_hst = H_IDLE;  next_done = 1'b1;  next_ready = 1'b1;
        end
      end
    endcase
    case (hst)
      H_START: begin
        scl_hi = ph == 2'h1 || ph == 2'h2;  sda_low = ph[1];
      end
      H_STOP: begin
        scl_hi = ph != 2'h0;  sda_low = !ph[1];
      end
      H_TX: begin
        scl_hi = ph == 2'h1 || ph == 2'h2;
        sda_low = bitn != ACK_SLOT && !shreg[WORD_W-1];
      end
      H_RX: begin
        scl_hi = ph == 2'h1 || ph == 2'h2;
        sda_low = bitn == ACK_SLOT && remain != '0;
      end
      default: begin
        scl_hi = 1'b1;  sda_low = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hst <= H_IDLE;  what <= W_DEV1;  op <= OP_WRITE;  qcnt <= '0;
      ph <= '0;  bitn <= '0;  shreg <= '0;  sel <= '0;  addr <= '0;
      remain <= '0;  nack <= 1'b0;  samp <= 1'b1;  cmd_ready_o <= 1'b0;
      wr_take_o <= 1'b0;  rd_valid_o <= 1'b0;  rd_data_o <= '0;
      done_o <= 1'b0;  nack_o <= 1'b0;  link.scl <= 1'b1;
      link.m_sda_oe_n <= 1'b1;  link.m_sda_o <= 1'b0;
    end else begin
      hst <= next_hst;  what <= next_what;  op <= next_op;
      qcnt <= next_qcnt;  ph <= next_ph;  bitn <= next_bitn;
      shreg <= next_shreg;  sel <= next_sel;  addr <= next_addr;
      remain <= next_remain;  nack <= next_nack;  samp <= next_samp;
      cmd_ready_o <= next_ready || (hst == H_IDLE && !cmd_valid_i);
      wr_take_o <= next_take;  rd_valid_o <= next_rd_valid;
      rd_data_o <= next_rd_data;  done_o <= next_done;
      nack_o <= next_done ? nack : nack_o;
      link.scl <= scl_hi;  link.m_sda_oe_n <= ~sda_low;
      link.m_sda_o <= 1'b0;
    end
  end
endmodule // eep_host_end

// *** eep_assertions.sv ***
// concurrent checks on the two-wire link and the eeprom write timer
`timescale 1ns/1ps
module eep_assertions #(
  parameter int WR_CYCLES = eep_pkg::WR_CYCLES_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_o,
  input wire logic s_sda_oe_n,
  input wire logic busy_o
);
  int   busy_cnt;
  int   next_busy_cnt;
  int   since_stop;
  int   next_since_stop;
  logic scl_q;
  logic sda_q;
  ////////////////////////////////////////
  // stop seen on raw wires; host drives them from this clock
  always_comb begin
    next_busy_cnt = busy_o ? busy_cnt + 1 : 0;
    next_since_stop = since_stop < 255 ? since_stop + 1 : since_stop;
    if (scl && scl_q && sda && !sda_q) next_since_stop = 0;
  end
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_cnt   <= 0;
      since_stop <= 255;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      busy_cnt   <= next_busy_cnt;
      since_stop <= next_since_stop;
      scl_q      <= scl;
      sda_q      <= sda;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  sequence drive_hold;
    !s_sda_oe_n [*8];
  endsequence
  sequence busy_hold;
    busy_o [*8];
  endsequence
  AST_BUSY_QUIET: assert property (busy_o |-> s_sda_oe_n)
    else $error("data line driven while busy");
  AST_BUSY_MAX: assert property (busy_o |-> busy_cnt < WR_CYCLES)
    else $error("write cycle too long");
  AST_BUSY_FULL: assert property ($fell(busy_o) |->
    $past(busy_cnt) >= WR_CYCLES - 4)
    else $error("write cycle cut short");
  AST_BUSY_AT_STOP: assert property ($rose(busy_o) |-> since_stop <= 8)
    else $error("write cycle not started by stop");
  AST_ONE_CYCLE: assert property ($rose(busy_o) |-> busy_hold)
    else $error("write cycle broken up");
  AST_SDA_STEADY: assert property (scl && $past(scl) |->
    $stable(s_sda_oe_n))
    else $error("memory changed data while clock high");
  AST_DRIVE_SPAN: assert property ($fell(s_sda_oe_n) |-> drive_hold)
    else $error("memory drive too short");
  AST_OPEN_DRAIN: assert property (!s_sda_oe_n |-> !s_sda_o)
    else $error("memory drove a high level");
  AST_SCL_LOW: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
endmodule // eep_assertions

// *** test_serial_eeprom_two_wire_access.sv ***
// self-checking bench joining host end and eeprom end
`timescale 1ns/1ps
module test_serial_eeprom_two_wire_access;
  import eep_pkg::*;
  localparam int WR_CYC = 1000;
  localparam int ASZ    = MEM_KBIT_DEF * KBIT_BYTES;
  logic       clk_sys_i = 1'b0;
  logic       rstn_i    = 1'b0;
  logic       cmd_valid = 1'b0;
  eep_op_e    cmd_op    = OP_WRITE;
  logic [2:0] cmd_sel   = 3'h0;
  logic [7:0] cmd_addr  = 8'h00;
  logic [3:0] cmd_len   = 4'h0;
  logic [7:0] wr_data   = 8'h00;
  logic       cmd_ready;
  logic       wr_take;
  logic       rd_valid;
  logic [7:0] rd_data;
  logic       done;
  logic       nack;
  logic       busy;
  logic       got_nack;
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  int         mem [ASZ];
  int         ptr         = 0;
  int         seed        = 27;
  int         miscompares = 0;
  int         n_compared  = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////
  eep_link_if u_link ();
  // 16 kbit part: select pins unused, tied low
  eep_mem_end #(.MEM_KBIT(MEM_KBIT_DEF), .WR_CYCLES(WR_CYC)) u_eep_mem_end (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link(u_link.memory),
    .device_select_pin_0_i(1'b0), .device_select_pin_1_i(1'b0),
    .device_select_pin_2_i(1'b0), .busy_o(busy));
  eep_host_end u_eep_host_end (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link(u_link.host),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op),
    .cmd_sel_i(cmd_sel), .cmd_addr_i(cmd_addr), .cmd_len_i(cmd_len),
    .wr_data_i(wr_data), .wr_take_o(wr_take), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .done_o(done), .nack_o(nack));
  eep_assertions #(.WR_CYCLES(WR_CYC)) u_eep_assertions (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .scl(u_link.scl),
    .sda(u_link.sda), .s_sda_o(u_link.s_sda_o),
    .s_sda_oe_n(u_link.s_sda_oe_n), .busy_o(busy));
  ////////////////////////////////////////
  always @(posedge clk_sys_i) begin
    if (wr_take === 1'b1 && wq.size() > 1) begin
      void'(wq.pop_front());
      wr_data <= wq[0];
    end
    if (rd_valid === 1'b1) rq.push_back(rd_data);
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic run_cmd(input eep_op_e op, input logic [2:0] sel,
                         input logic [7:0] addr, input int cnt);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_sel   <= sel;
    cmd_addr  <= addr;
    cmd_len   <= 4'(cnt - 1);
    if (wq.size() > 0) wr_data <= wq[0];
    do @(posedge clk_sys_i); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (done !== 1'b1 && n < 60000);
    if (done !== 1'b1) begin
      miscompares++;
      $display("BAD %0t command never finished", $time);
    end
    got_nack = nack;
    $display("test %s ended at %0t", op.name(), $time);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge clk_sys_i);
    chk1(busy, 1'b0, "write cycle still running");
  endtask
  // page writes wrap inside the page, and so does the counter
  task automatic do_write(input logic [2:0] blk, input logic [7:0] wa,
                          input int cnt);
    int base;
    int a;
    base = int'({blk, wa});
    wq = {};
    for (int i = 0; i < cnt; i++) begin
      a = (base & ~15) | ((base + i) & 15);
      mem[a] = $random(seed) & 255;
      wq.push_back(8'(mem[a]));
      ptr = (a & ~15) | ((a + 1) & 15);
    end
    run_cmd(OP_WRITE, blk, wa, cnt);
    chk1(got_nack, 1'b0, "write nack");
    chk1(busy, 1'b1, "no write cycle after stop");
  endtask
  // reads run over the whole array and wrap to zero
  task automatic do_read(input eep_op_e op, input logic [2:0] blk,
                         input logic [7:0] wa, input int cnt);
    rq = {};
    if (op == OP_RAND_READ) ptr = int'({blk, wa});
    run_cmd(op, blk, wa, cnt);
    chk1(got_nack, 1'b0, "read nack");
    chk8(8'(rq.size()), 8'(cnt), "read count");
    for (int i = 0; i < cnt; i++) begin
      chk8(rq[i], 8'(mem[ptr]), "read data");
      ptr = (ptr + 1) % ASZ;
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    do_write(3'h0, 8'h00, 2);
    run_cmd(OP_POLL, 3'h0, 8'h00, 1);
    chk1(got_nack, 1'b1, "poll while busy");
    wait_idle();
    run_cmd(OP_POLL, 3'h0, 8'h00, 1);
    chk1(got_nack, 1'b0, "poll when idle");
    do_write(3'h7, 8'hff, 2);
    wait_idle();
    do_read(OP_RAND_READ, 3'h7, 8'hff, 2);
    do_read(OP_CUR_READ, 3'h0, 8'h00, 1);
    wrap_up();
  end
  // about 35k cycles expected; the margin covers slow acks
  initial begin
    repeat (80000) @(posedge clk_sys_i);
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up();
  end
endmodule // test_serial_eeprom_two_wire_access
